/* File: include/rpi_defines.svh */
// register map, field positions, reset values and timing of the pin block
`ifndef RPI_DEFINES_SVH
`define RPI_DEFINES_SVH
// register byte offsets
`define RPI_OFF_CTRL 12'h000
`define RPI_OFF_BAUD 12'h004
`define RPI_OFF_TXDATA 12'h008
`define RPI_OFF_RXDATA 12'h00C
`define RPI_OFF_STATUS 12'h010
// control fields
`define RPI_CTRL_RXIND 0
`define RPI_CTRL_FLOWIN 1
`define RPI_CTRL_RS485 2
`define RPI_CTRL_SMODE_LO 3
`define RPI_CTRL_SMODE_HI 4
`define RPI_CTRL_REBOOT 5
// status and receive data fields
`define RPI_STAT_CMD 0
`define RPI_STAT_OVR 1
`define RPI_STAT_TXBUSY 2
`define RPI_STAT_SLEEP 3
`define RPI_STAT_STRAP 4
`define RPI_STAT_TXFULL 5
`define RPI_RXD_VALID 8
// reset values and codes
`define RPI_BAUD_RST 16'h5161
`define RPI_SMODE_PIN 2'h1
`define RPI_ESC_CHAR 8'h2B
// timing
`define RPI_CLK_NS 5
`define RPI_RST_MIN_NS 90000
`define RPI_RST_OUT_NS 1000
`endif

/* File: include/rpi_pkg.sv */
// types shared by the pin block modules
package rpi_pkg;
	typedef enum logic [1:0] {
		RPI_ST_PULSE = 2'b01,
		RPI_ST_RUN = 2'b10
	} rpi_state_t;

	typedef struct packed {
		logic [4:0] sy1;
		logic [4:0] sy2;
		rpi_state_t st;
		logic [15:0] pcnt;
		logic [19:0] lcnt;
		logic armed;
		logic reboot;
		logic strap;
		logic cmd;
		logic ovr;
		logic [1:0] plus;
		logic rxind;
		logic flowin;
		logic rs485;
		logic [1:0] smode;
		logic [15:0] div;
		logic txh_v;
		logic [7:0] txh_d;
		logic [31:0] rdata;
		logic slverr;
		logic slp;
		logic cts;
		logic txp;
		logic rxa;
		logic onsl;
	} rpi_top_st_t;

	typedef struct packed {
		logic [15:0] tcnt;
		logic [3:0] tbit;
		logic [9:0] tsh;
		logic tbusy;
		logic [15:0] rcnt;
		logic [3:0] rbit;
		logic [7:0] rsh;
		logic rbusy;
		logic rprev;
		logic rv;
		logic [7:0] rd;
	} rpi_uart_st_t;
endpackage : rpi_pkg

/* File: include/rpi_strm_if.sv */
// byte stream with valid and ready between the pin block modules
`timescale 1ns/1ps
`default_nettype none
interface rpi_strm_if #(parameter int W = 8) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : rpi_strm_if
`default_nettype wire

/* File: rtl/rpi_fifo.sv */
// synchronous fifo, depth a power of two
`timescale 1ns/1ps
`default_nettype none
module rpi_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill and drain sides
	rpi_strm_if.snk wr,
	rpi_strm_if.src rd
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} rpi_fifo_st_t;

	logic [W-1:0] mem [D];
	rpi_fifo_st_t q;
	rpi_fifo_st_t d;
	logic full;
	logic empty;

	// extra pointer bit tells full from empty
	assign empty = q.wp == q.rp;
	assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[q.rp[AW-1:0]];

	// pointer advance
	always_comb begin
		d = q;
		if (wr.valid && !full) begin
			d.wp = q.wp + 1'b1;
		end
		if (rd.ready && !empty) begin
			d.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// storage needs no reset
	always_ff @(posedge clk) begin
		if (wr.valid && !full) begin
			mem[q.wp[AW-1:0]] <= wr.data;
		end
	end
endmodule : rpi_fifo
`default_nettype wire

/* File: rtl/rpi_uart.sv */
// 8n1 serial transmitter and receiver, bit time set by a divisor
`timescale 1ns/1ps
`default_nettype none
module rpi_uart (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// clocks per bit
	input wire logic [15:0] div,
	// serial lines, rxd already synchronised
	input wire logic rxd,
	output logic txd,
	output logic tx_busy,
	// byte streams
	rpi_strm_if.snk tx,
	rpi_strm_if.src rx
);
	rpi_pkg::rpi_uart_st_t q;
	rpi_pkg::rpi_uart_st_t d;

	assign txd = q.tsh[0];
	assign tx_busy = q.tbusy;
	assign tx.ready = !q.tbusy;
	assign rx.valid = q.rv;
	assign rx.data = q.rd;

	always_comb begin
		d = q;
		d.rv = 1'b0;
		d.rprev = rxd;
		// transmit: start, eight data bits lsb first, stop
		if (!q.tbusy) begin
			if (tx.valid) begin
				d.tsh = {1'b1, tx.data, 1'b0};
				d.tbusy = 1'b1;
				d.tcnt = div - 16'h0001;
				d.tbit = 4'h0;
			end
		end else if (q.tcnt == 16'h0000) begin
			d.tsh = {1'b1, q.tsh[9:1]};
			d.tcnt = div - 16'h0001;
			d.tbit = q.tbit + 4'h1;
			if (q.tbit == 4'h9) begin
				d.tbusy = 1'b0;
			end
		end else begin
			d.tcnt = q.tcnt - 16'h0001;
		end
		// receive: sample mid-bit after a falling edge
		if (!q.rbusy) begin
			if (q.rprev && !rxd) begin
				d.rbusy = 1'b1;
				d.rcnt = {1'b0, div[15:1]};
				d.rbit = 4'h0;
			end
		end else if (q.rcnt == 16'h0000) begin
			d.rcnt = div - 16'h0001;
			d.rbit = q.rbit + 4'h1;
			if (q.rbit == 4'h0 && rxd) begin
				d.rbusy = 1'b0; // glitch, not a start bit
			end else if (q.rbit == 4'h9) begin
				d.rbusy = 1'b0;
				d.rv = rxd; // framing error drops the byte
				d.rd = q.rsh;
			end else if (q.rbit != 4'h0) begin
				d.rsh = {rxd, q.rsh[7:1]};
			end
		end else begin
			d.rcnt = q.rcnt - 16'h0001;
		end
	end

	// idle line is high, so shifter and edge history reset to ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.tsh <= '1;
			q.rprev <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule : rpi_uart
`default_nettype wire

/* File: rtl/rpi_pin_if.sv */
// host pin interface of the serial rf modem with its apb register file
// Operation
// - serial bytes leave on serial_out_pin and arrive on serial_in_pin, async uart.
// - with rx indicator enabled, rx_activity_out high only during rf reception.
// - reset pin held low at least 90 us reboots; shorter may be ignored.
// - device pulls its open-drain reset pin low on reboot and power-up.
// - config pin sampled at power-up enters command mode; escape +++ also.
// - flow_permit_out low when bytes can be accepted; host sends only then.
// - in rs-485 mode flow_permit_out becomes the transceiver transmit enable.
// - on/sleep output high while awake, low while asleep.
// - tx/power output pulses low during rf transmit, high otherwise when awake.
// - host hold input ignored unless enabled; then it paces outgoing bytes.
// - sleep input ignored unless pin sleep mode selected; active high.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rpi_defines.svh"
module rpi_pin_if #(
	parameter int RST_MIN_CYC =
		(`RPI_RST_MIN_NS + `RPI_CLK_NS - 1) / `RPI_CLK_NS,
	parameter int RX_DEPTH = 32
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host serial lines
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	// flow control
	output logic flow_permit_out,
	input wire logic host_flow_hold_in,
	// status indicators
	output logic rx_activity_out,
	output logic tx_power_status_out,
	output logic on_sleep_out,
	// open-drain reset pin
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// strap and sleep pins
	input wire logic config_pin_in,
	input wire logic sleep_control_in,
	// radio core
	input wire logic rf_rx_busy,
	input wire logic rf_tx_busy,
	output logic reboot_req,
	output logic cmd_mode
);
	// own reset pulse length, rounded up
	localparam int RST_OUT_CYC =
		(`RPI_RST_OUT_NS + `RPI_CLK_NS - 1) / `RPI_CLK_NS;
	// synchroniser bit positions
	localparam int SY_SIN = 0;
	localparam int SY_RST = 1;
	localparam int SY_CFG = 2;
	localparam int SY_HOLD = 3;
	localparam int SY_SLP = 4;

	rpi_pkg::rpi_top_st_t q;
	rpi_pkg::rpi_top_st_t d;
	logic tx_busy;
	logic tx_en;
	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic ext_trig;
	logic sw_reboot;
	logic cmd_set;
	logic cmd_clr;
	logic ovr_set;
	logic ovr_clr;

	rpi_strm_if #(.W(8)) tx_s ();
	rpi_strm_if #(.W(8)) rx_s ();
	rpi_strm_if #(.W(8)) rxr ();

	// address compare, shared by read and write decode
	function automatic logic rpi_sel(input logic [11:0] a,
		input logic [11:0] off);
		rpi_sel = a == off;
	endfunction : rpi_sel

	function automatic logic rpi_mapped(input logic [11:0] a);
		rpi_mapped = rpi_sel(a, `RPI_OFF_CTRL) ||
			rpi_sel(a, `RPI_OFF_BAUD) ||
			rpi_sel(a, `RPI_OFF_TXDATA) ||
			rpi_sel(a, `RPI_OFF_RXDATA) ||
			rpi_sel(a, `RPI_OFF_STATUS);
	endfunction : rpi_mapped

	// apb answers with no wait states
	assign pready = 1'b1;
	assign prdata = q.rdata;
	assign pslverr = psel && penable && q.slverr;

	// outputs straight from flops
	assign flow_permit_out = q.cts;
	assign rx_activity_out = q.rxa;
	assign tx_power_status_out = q.txp;
	assign on_sleep_out = q.onsl;
	assign reboot_req = q.reboot;
	assign cmd_mode = q.cmd;

	// open drain: only ever pulls low
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = q.st == rpi_pkg::RPI_ST_PULSE;

	// a byte only starts while running, awake and not held by the host
	assign tx_en = (q.st == rpi_pkg::RPI_ST_RUN) && !q.slp &&
		!(q.flowin && q.sy2[SY_HOLD]);
	assign tx_s.valid = q.txh_v && tx_en;
	assign tx_s.data = q.txh_d;

	// pop only a byte that the setup phase actually showed
	assign rxr.ready = rd_acc && rpi_sel(paddr, `RPI_OFF_RXDATA) &&
		q.rdata[`RPI_RXD_VALID];

	// serial engine toward the host
	rpi_uart u_uart (
		.clk(pclk),
		.rst_n(presetn),
		.div(q.div),
		.rxd(q.sy2[SY_SIN]),
		.txd(serial_out_pin),
		.tx_busy(tx_busy),
		.tx(tx_s),
		.rx(rx_s)
	);

	// received bytes wait here for software
	rpi_fifo #(
		.W(8),
		.D(RX_DEPTH)
	) u_rx_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.wr(rx_s),
		.rd(rxr)
	);

	always_comb begin
		d = q;
		setup = psel && !penable;
		wr_acc = psel && penable && pwrite;
		rd_acc = psel && penable && !pwrite;
		ext_trig = 1'b0;
		sw_reboot = 1'b0;
		cmd_set = 1'b0;
		cmd_clr = 1'b0;
		ovr_set = 1'b0;
		ovr_clr = 1'b0;
		d.reboot = 1'b0;

		// pins from outside pass two flops first
		d.sy1 = {sleep_control_in, host_flow_hold_in, config_pin_in,
			reset_pin_in, serial_in_pin};
		d.sy2 = q.sy1;

		// reset pin watch: count a low level that the device did not drive
		if (q.st != rpi_pkg::RPI_ST_RUN) begin
			d.lcnt = 20'h00000;
			d.armed = 1'b0;
		end else if (q.sy2[SY_RST]) begin
			d.lcnt = 20'h00000;
			d.armed = 1'b1;
		end else if (q.armed) begin
			if (q.lcnt == 20'(RST_MIN_CYC - 1)) begin
				ext_trig = 1'b1;
				d.armed = 1'b0;
				d.lcnt = 20'h00000;
			end else begin
				d.lcnt = q.lcnt + 20'h00001;
			end
		end

		// apb write in the access phase
		if (wr_acc) begin
			unique case (1'b1)
				rpi_sel(paddr, `RPI_OFF_CTRL): begin
					d.rxind = pwdata[`RPI_CTRL_RXIND];
					d.flowin = pwdata[`RPI_CTRL_FLOWIN];
					d.rs485 = pwdata[`RPI_CTRL_RS485];
					d.smode = pwdata[`RPI_CTRL_SMODE_HI:`RPI_CTRL_SMODE_LO];
					sw_reboot = pwdata[`RPI_CTRL_REBOOT];
				end
				rpi_sel(paddr, `RPI_OFF_BAUD): begin
					d.div = pwdata[15:0];
				end
				rpi_sel(paddr, `RPI_OFF_TXDATA): begin
					// a full holding register drops the write
					if (!q.txh_v) begin
						d.txh_v = 1'b1;
						d.txh_d = pwdata[7:0];
					end
				end
				rpi_sel(paddr, `RPI_OFF_STATUS): begin
					cmd_clr = pwdata[`RPI_STAT_CMD];
					ovr_clr = pwdata[`RPI_STAT_OVR];
				end
				default: begin
				end
			endcase
		end

		// power-up and reboot pulse on the reset pin
		unique case (q.st)
			rpi_pkg::RPI_ST_PULSE: begin
				if (q.pcnt == 16'(RST_OUT_CYC - 1)) begin
					d.st = rpi_pkg::RPI_ST_RUN;
					d.pcnt = 16'h0000;
					// strap sampled as the pulse ends; low asks for commands
					d.strap = !q.sy2[SY_CFG];
					cmd_set = !q.sy2[SY_CFG];
				end else begin
					d.pcnt = q.pcnt + 16'h0001;
				end
			end
			rpi_pkg::RPI_ST_RUN: begin
				if (ext_trig || sw_reboot) begin
					d.st = rpi_pkg::RPI_ST_PULSE;
					d.pcnt = 16'h0000;
					d.reboot = 1'b1;
				end
			end
		endcase

		// escape of three plus bytes in a row also enters command mode
		if (rx_s.valid) begin
			if (rx_s.data == `RPI_ESC_CHAR) begin
				if (q.plus == 2'h2) begin
					cmd_set = 1'b1;
					d.plus = 2'h0;
				end else begin
					d.plus = q.plus + 2'h1;
				end
			end else begin
				d.plus = 2'h0;
			end
		end

		// a byte arriving into a full fifo is lost and flagged
		ovr_set = rx_s.valid && !rx_s.ready;

		// sticky flags: a set in the clearing cycle wins
		d.cmd = (q.cmd && !cmd_clr) || cmd_set;
		d.ovr = (q.ovr && !ovr_clr) || ovr_set;

		// holding register empties when the serial engine takes it
		if (tx_s.valid && tx_s.ready) begin
			d.txh_v = 1'b0;
		end

		// sleep follows the pin only in pin sleep mode
		d.slp = (q.smode == `RPI_SMODE_PIN) && q.sy2[SY_SLP];

		// flow pin: clear-to-send, or driver enable that rises with start
		if (q.rs485) begin
			d.cts = tx_busy || (tx_s.valid && tx_s.ready);
		end else begin
			// one flop late; the host must allow one byte of slack
			d.cts = !rx_s.ready || q.slp ||
				(q.st != rpi_pkg::RPI_ST_RUN);
		end

		// indicators
		d.rxa = q.rxind && rf_rx_busy && !q.slp;
		d.txp = !q.slp && !rf_tx_busy;
		d.onsl = !q.slp;

		// apb setup phase: capture read data and the error answer
		if (setup) begin
			d.slverr = !rpi_mapped(paddr);
			d.rdata = 32'h0000_0000;
			if (!pwrite) begin
				unique case (1'b1)
					rpi_sel(paddr, `RPI_OFF_CTRL): begin
						d.rdata[`RPI_CTRL_RXIND] = q.rxind;
						d.rdata[`RPI_CTRL_FLOWIN] = q.flowin;
						d.rdata[`RPI_CTRL_RS485] = q.rs485;
						d.rdata[`RPI_CTRL_SMODE_HI:`RPI_CTRL_SMODE_LO] =
							q.smode;
					end
					rpi_sel(paddr, `RPI_OFF_BAUD): begin
						d.rdata[15:0] = q.div;
					end
					rpi_sel(paddr, `RPI_OFF_RXDATA): begin
						d.rdata[7:0] = rxr.data;
						d.rdata[`RPI_RXD_VALID] = rxr.valid;
					end
					rpi_sel(paddr, `RPI_OFF_STATUS): begin
						d.rdata[`RPI_STAT_CMD] = q.cmd;
						d.rdata[`RPI_STAT_OVR] = q.ovr;
						d.rdata[`RPI_STAT_TXBUSY] = tx_busy;
						d.rdata[`RPI_STAT_SLEEP] = q.slp;
						d.rdata[`RPI_STAT_STRAP] = q.strap;
						d.rdata[`RPI_STAT_TXFULL] = q.txh_v;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// state register; pins assumed idle high until synchronised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.sy1 <= '1;
			q.sy2 <= '1;
			q.st <= rpi_pkg::RPI_ST_PULSE;
			q.div <= `RPI_BAUD_RST;
			q.cts <= 1'b1;
			q.txp <= 1'b1;
			q.onsl <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule : rpi_pin_if
`default_nettype wire

/* File: dv/rpi_pin_if_props.sv */
// concurrent checks on the ports of the pin block
`timescale 1ns/1ps
`default_nettype none
module rpi_pin_if_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic serial_out_pin,
	input wire logic rx_activity_out,
	input wire logic tx_power_status_out,
	input wire logic on_sleep_out,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	// radio core
	input wire logic rf_rx_busy,
	input wire logic rf_tx_busy,
	input wire logic reboot_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a reboot holds the line for a stretch, never a glitch
	sequence s_pull;
		reset_pin_oe [*8];
	endsequence
	// bus answers
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	slverr_a: assert property (pslverr |-> psel && penable && prdata == 32'h0)
		else $error("error response outside access or with data");
	// indicators
	rx_act_a: assert property (
		rx_activity_out |-> $past(rf_rx_busy) && on_sleep_out)
		else $error("rx activity without reception");
	tx_busy_low_a: assert property (rf_tx_busy |=> !tx_power_status_out)
		else $error("tx power high during transmission");
	tx_idle_high_a: assert property (
		on_sleep_out && !$past(rf_tx_busy) |-> tx_power_status_out)
		else $error("tx power low while awake and idle");
	sleep_low_a: assert property (
		!on_sleep_out |-> !tx_power_status_out && !rx_activity_out)
		else $error("indicators active while asleep");
	// open-drain reset line
	od_drive_a: assert property (reset_pin_oe |-> !reset_pin_out)
		else $error("reset line driven high");
	reboot_pull_a: assert property (reboot_req |-> ##[0:2] s_pull)
		else $error("reboot without reset line pulse");
	pull_cause_a: assert property ($rose(reset_pin_oe) |-> reboot_req)
		else $error("reset line pulled without a reboot");
	// a start bit only leaves a running, awake device
	start_gated_a: assert property (
		$fell(serial_out_pin) |-> !reset_pin_oe && on_sleep_out)
		else $error("start bit while held or asleep");
endmodule : rpi_pin_if_props
bind rpi_pin_if rpi_pin_if_props i_rpi_pin_if_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
	.rx_activity_out(rx_activity_out), .on_sleep_out(on_sleep_out),
	.tx_power_status_out(tx_power_status_out), .reset_pin_oe(reset_pin_oe),
	.reset_pin_out(reset_pin_out), .rf_rx_busy(rf_rx_busy),
	.rf_tx_busy(rf_tx_busy), .reboot_req(reboot_req));
`default_nettype wire

/* File: dv/rpi_host_model.sv */
// host uart model: sends when permitted, collects what the device sends
`timescale 1ns/1ps
`default_nettype none
module rpi_host_model #(
	parameter int BIT = 16
) (
	// clock
	input wire logic clk,
	// serial lines
	output logic txd,
	input wire logic rxd,
	// flow control from the device, low means go
	input wire logic permit_n
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// idle line is high
	initial txd = 1'b1;
	// one 8n1 frame, lsb first, started only while permitted
	task automatic send(input logic [7:0] b);
		while (permit_n !== 1'b0) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			txd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT) @(posedge clk);
		end
	endtask : send
	// sample each frame mid-bit, drop it on a bad stop bit
	always begin
		@(negedge rxd);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			sh[i] = rxd;
		end
		repeat (BIT) @(posedge clk);
		if (rxd === 1'b1)
			got.push_back(sh);
	end
endmodule : rpi_host_model
`default_nettype wire

/* File: dv/rpi_pin_if_test.sv */
// self-checking bench for the pin block with a host uart model
`timescale 1ns/1ps
`default_nettype none
`include "rpi_defines.svh"
module rpi_pin_if_test;
	localparam int BIT = 16;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic sin, sout, permit, hold, rxa, txp, onsl, rp_in, rp_out, rp_oe;
	logic cfg, slp, rfrx, rftx, rbt, cmd, rp_low;
	int failures, cmp_count, n;
	// open-drain reset line with its pull-up
	assign rp_in = !((rp_oe && !rp_out) || rp_low);
	rpi_pin_if #(.RST_MIN_CYC(20)) i_rpi_pin_if (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin(sout),
		.flow_permit_out(permit), .host_flow_hold_in(hold),
		.rx_activity_out(rxa), .tx_power_status_out(txp),
		.on_sleep_out(onsl), .reset_pin_in(rp_in), .reset_pin_out(rp_out),
		.reset_pin_oe(rp_oe), .config_pin_in(cfg), .sleep_control_in(slp),
		.rf_rx_busy(rfrx), .rf_tx_busy(rftx), .reboot_req(rbt),
		.cmd_mode(cmd));
	rpi_host_model #(.BIT(BIT)) i_rpi_host_model (.clk(pclk), .txd(sin),
		.rxd(sout), .permit_n(permit));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer, entered just after an edge; leaves r and err
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no fixed wait count; only the watchdog ends a stuck access
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	// wait until the host has collected c bytes
	task automatic wait_rx(input int c);
		for (n = 0; n < 400 && i_rpi_host_model.got.size() < c; n++)
			@(posedge pclk);
		// a byte that never arrives is a mismatch
		if (i_rpi_host_model.got.size() < c)
			failures++;
	endtask : wait_rx
	task automatic results;
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// 200 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// a hang ends the run as a failure
	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		results();
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{hold, cfg, slp, rfrx, rftx, rp_low} = '0;
		repeat (5) @(posedge pclk);
		chk(32'(rp_oe), 32'h1);
		presetn <= 1'b1;
		for (n = 0; n < 400 && rp_oe !== 1'b0; n++) @(posedge pclk);
		chk(32'(n > 190 && n < 210), 32'h1);
		repeat (2) @(posedge pclk);
		chk(32'(cmd), 32'h1);
		rd(`RPI_OFF_STATUS, 32'h11);
		apb(1'b1, `RPI_OFF_STATUS, 32'h1);
		chk(32'(cmd), 32'h0);
		rd(`RPI_OFF_CTRL, 32'h0);
		rd(`RPI_OFF_BAUD, 32'(`RPI_BAUD_RST));
		rd(`RPI_OFF_TXDATA, 32'h0);
		rd(12'h020, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, `RPI_OFF_BAUD, BIT);
		// hold is ignored until enabled, then it stops the next byte
		hold <= 1'b1;
		apb(1'b1, `RPI_OFF_TXDATA, 32'hA5);
		wait_rx(1);
		chk(32'(i_rpi_host_model.got[0]), 32'hA5);
		apb(1'b1, `RPI_OFF_CTRL, 32'h2);
		apb(1'b1, `RPI_OFF_TXDATA, 32'h3C);
		repeat (300) @(posedge pclk);
		chk(i_rpi_host_model.got.size(), 32'h1);
		rd(`RPI_OFF_STATUS, 32'h30);
		hold <= 1'b0;
		wait_rx(2);
		chk(32'(i_rpi_host_model.got[1]), 32'h3C);
		// rs-485 driver enable spans the character
		apb(1'b1, `RPI_OFF_CTRL, 32'h4);
		// let the previous stop bit finish before judging the enable
		repeat (BIT) @(posedge pclk);
		chk(32'(permit), 32'h0);
		apb(1'b1, `RPI_OFF_TXDATA, 32'h81);
		repeat (8) @(posedge pclk);
		chk(32'(permit), 32'h1);
		rd(`RPI_OFF_STATUS, 32'h14);
		wait_rx(3);
		repeat (2 * BIT) @(posedge pclk);
		chk(32'(permit), 32'h0);
		chk(32'(i_rpi_host_model.got[2]), 32'h81);
		apb(1'b1, `RPI_OFF_CTRL, 32'h0);
		// three escape characters enter command mode
		for (int i = 0; i < 3; i++) i_rpi_host_model.send(8'h2B);
		repeat (4) @(posedge pclk);
		chk(32'(cmd), 32'h1);
		for (int i = 0; i < 3; i++) rd(`RPI_OFF_RXDATA, 32'h12B);
		// fill the fifo until it stops the host, then drain it
		for (int i = 0; i < 32; i++) i_rpi_host_model.send(8'(i));
		repeat (4) @(posedge pclk);
		chk(32'(permit), 32'h1);
		for (int i = 0; i < 32; i++) rd(`RPI_OFF_RXDATA, 32'h100 | i);
		chk(32'(permit), 32'h0);
		// indicators
		apb(1'b1, `RPI_OFF_CTRL, 32'h1);
		rfrx <= 1'b1;
		rftx <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(rxa), 32'h1);
		chk(32'(txp), 32'h0);
		apb(1'b1, `RPI_OFF_CTRL, 32'h0);
		rftx <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'(rxa), 32'h0);
		chk(32'(txp), 32'h1);
		rfrx <= 1'b0;
		// sleep input counts only in pin sleep mode
		slp <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(32'(onsl), 32'h1);
		apb(1'b1, `RPI_OFF_CTRL, 32'h8);
		repeat (5) @(posedge pclk);
		chk(32'(onsl), 32'h0);
		rd(`RPI_OFF_STATUS, 32'h19);
		slp <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(32'(onsl), 32'h1);
		// short reset pulse ignored, long one reboots
		rp_low <= 1'b1;
		repeat (10) @(posedge pclk);
		rp_low <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(32'(rp_oe), 32'h0);
		rp_low <= 1'b1;
		repeat (25) @(posedge pclk);
		rp_low <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(32'(rp_oe), 32'h1);
		repeat (250) @(posedge pclk);
		chk(32'(rp_oe), 32'h0);
		// software reboot pulls the line as well
		apb(1'b1, `RPI_OFF_CTRL, 32'h20);
		chk(32'(rp_oe), 32'h1);
		results();
	end
endmodule : rpi_pin_if_test
`default_nettype wire
